// >>> rtl/motion_pulse_output_former.sv
// Purpose: Forms command and direction lines for one motor axis
// Assumes: step_i pulses come from a profile generator, one per motion step
// Notes: Keep one idle cycle between steps in the pulse formats
// Behaviour
// - Three output formats selectable by a format setting
// - Pulse-direction format: pulses on command line, direction as a level
// - Pulse count gives distance, pulse rate gives speed
// - Direction line level shows positive or negative motion
// - Formats 0 to 3 select pulse and direction polarity
// - Two-line format: clockwise on command line, counter-clockwise on direction line
// - Clockwise pulses mean positive motion, counter-clockwise negative
// - Command counter counts up on clockwise, down on counter-clockwise
// - Quadrature: command line leads or lags direction line by a quarter cycle
// - Format 6 lead means clockwise; format 7 lag means clockwise
`timescale 1ns/100ps

`include "pulse_former_consts.svh"

module motion_pulse_output_former (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Format and step request
    input wire pulse_former_pkg::fmt_t fmt_i,
    input wire logic step_i,
    input wire logic ccw_i,
    // Driver lines and command position
    output logic cmd_o,
    output logic dir_o,
    output pulse_former_pkg::count_t count_o
);
    import pulse_former_pkg::*;

    // ----------------------------------------
    // Format decode
    // ----------------------------------------
    // Pulse-direction variants
    wire is_pd0 = (fmt_i == `FMT_PD0);
    wire is_pd1 = (fmt_i == `FMT_PD1);
    wire is_pd2 = (fmt_i == `FMT_PD2);
    wire is_pd3 = (fmt_i == `FMT_PD3);
    wire is_pd = is_pd0 || is_pd1 || is_pd2 || is_pd3;

    // Two-line format
    wire is_two = (fmt_i == `FMT_CWCCW);

    // Quadrature pair and the sense that means clockwise
    wire is_quad_lead = (fmt_i == `FMT_QUAD_LEAD);
    wire is_quad_lag = (fmt_i == `FMT_QUAD_LAG);
    wire is_quad = is_quad_lead || is_quad_lag;

    // Format codes with no output format hold both lines low
    wire is_off = !is_pd && !is_two && !is_quad;

    // Polarity bits of the pulse-direction variants
    wire pls_inv = fmt_i[`FMT_PLS_INV_BIT];
    wire dir_inv = fmt_i[`FMT_DIR_INV_BIT];

    // ----------------------------------------
    // Step capture
    // ----------------------------------------
    logic pulse;
    logic ccw_held;

    wire step_cw = step_i && !ccw_i;
    wire step_ccw = step_i && ccw_i;

    // Pulse is the step delayed by one cycle, so it is one cycle wide
    step_hold_reg #(
        .W(1),
        .RST(`LINE_RST)
    ) i_pulse_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(`ALWAYS_ON),
        .d_i(step_i),
        .q_o(pulse)
    );

    // Direction of the latest step, held as a level until the next step
    step_hold_reg #(
        .W(1),
        .RST(`LINE_RST)
    ) i_ccw_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(step_i),
        .d_i(ccw_i),
        .q_o(ccw_held)
    );

    // ----------------------------------------
    // Quadrature phase
    // ----------------------------------------
    phase_t phase;

    // Counting up makes the direction line lead, so the command line lags
    wire cmd_lags = ccw_i ^ is_quad_lag;
    wire [`PH_W-1:0] phase_up = phase + `PH_STEP;
    wire [`PH_W-1:0] phase_down = phase - `PH_STEP;
    wire [`PH_W-1:0] next_phase = cmd_lags ? phase_up : phase_down;

    // Phase moves one quarter per step and rests between steps
    step_hold_reg #(
        .W(`PH_W),
        .RST(`PH_RST)
    ) i_phase_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(step_i),
        .d_i(next_phase),
        .q_o(phase)
    );

    // ----------------------------------------
    // Command pulse counter
    // ----------------------------------------
    count_t count;

    // Wraps silently at either end; the profile generator bounds travel
    wire [`CNT_W-1:0] count_up = count + `CNT_STEP;
    wire [`CNT_W-1:0] count_down = count - `CNT_STEP;
    wire [`CNT_W-1:0] next_count = step_ccw ? count_down : count_up;

    step_hold_reg #(
        .W(`CNT_W),
        .RST(`CNT_RST)
    ) i_count_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(step_i),
        .d_i(next_count),
        .q_o(count)
    );

    // ----------------------------------------
    // Line forming
    // ----------------------------------------
    // Phase sequence 00,01,10,11 gives Gray levels on the two lines
    wire quad_cmd = phase[`PH_CMD_BIT];
    wire quad_dir = phase[`PH_CMD_BIT] ^ phase[`PH_LOW_BIT];

    // Pulse-direction: pulse on the command line, sense as a level
    wire pd_cmd = pulse ^ pls_inv;
    wire pd_dir = ccw_held ^ dir_inv;

    // Two-line: each sense pulses its own line
    wire two_cmd = pulse && !ccw_held;
    wire two_dir = pulse && ccw_held;

    logic next_cmd;
    logic next_dir;

    always_comb begin
        next_cmd = `LINE_RST;
        if (is_pd) begin
            next_cmd = pd_cmd;
        end else if (is_two) begin
            next_cmd = two_cmd;
        end else if (is_quad) begin
            next_cmd = quad_cmd;
        end else if (is_off) begin
            next_cmd = `LINE_RST;
        end else begin
            next_cmd = `LINE_RST;
        end
    end

    always_comb begin
        next_dir = `LINE_RST;
        if (is_pd) begin
            next_dir = pd_dir;
        end else if (is_two) begin
            next_dir = two_dir;
        end else if (is_quad) begin
            next_dir = quad_dir;
        end else if (is_off) begin
            next_dir = `LINE_RST;
        end else begin
            next_dir = `LINE_RST;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    // Lines come from flip-flops so the driver never sees decode glitches
    step_hold_reg #(
        .W(1),
        .RST(`LINE_RST)
    ) i_cmd_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(`ALWAYS_ON),
        .d_i(next_cmd),
        .q_o(cmd_o)
    );

    step_hold_reg #(
        .W(1),
        .RST(`LINE_RST)
    ) i_dir_reg (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .en_i(`ALWAYS_ON),
        .d_i(next_dir),
        .q_o(dir_o)
    );

    assign count_o = count;
endmodule

// ----------------------------------------
// Enabled register
// ----------------------------------------
// One register with asynchronous reset to a given value
module step_hold_reg #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_o <= RST;
        end else if (en_i) begin
            q_o <= d_i;
        end
    end
endmodule

// >>> common/pulse_former_consts.svh
// Purpose: Constants for the motion pulse output former
// Assumes: Included by the package and the design file
// Notes: Format codes follow the mode numbering of the pulse output setting
`ifndef PULSE_FORMER_CONSTS_SVH
`define PULSE_FORMER_CONSTS_SVH

`define FMT_W 3
`define FMT_PD0 3'h0
`define FMT_PD1 3'h1
`define FMT_PD2 3'h2
`define FMT_PD3 3'h3
`define FMT_CWCCW 3'h4
`define FMT_QUAD_LEAD 3'h6
`define FMT_QUAD_LAG 3'h7
`define CNT_W 32
`define CNT_RST 32'h0000_0000
`define PH_W 2
`define PH_RST 2'h0
`define PH_STEP 2'h1
`define PH_CMD_BIT 1
`define PH_LOW_BIT 0
`define FMT_PLS_INV_BIT 0
`define FMT_DIR_INV_BIT 1
`define CNT_STEP 32'h0000_0001
`define LINE_RST 1'h0
`define ALWAYS_ON 1'h1

`endif

// >>> common/pulse_former_pkg.sv
// Purpose: Types for the motion pulse output former
// Assumes: Constants header present in common/
// Notes: Types only
`include "pulse_former_consts.svh"

package pulse_former_pkg;
    typedef logic [`FMT_W-1:0] fmt_t;
    typedef logic [`CNT_W-1:0] count_t;
    typedef logic [`PH_W-1:0] phase_t;
endpackage

// >>> sim/mpa_asserts.sv
// Purpose: port checks
// Assumes: fmt_i steady
// Notes: none
`timescale 1ns/100ps
module mpa_asserts import pulse_former_pkg::*; (
input logic clk_i,rst_n_i,step_i,ccw_i,cmd_o,dir_o,
input fmt_t fmt_i,
input count_t count_o);
default clocking @(posedge clk_i); endclocking
default disable iff(!rst_n_i);
wire s=step_i&&fmt_i==0;
AST_UP: assert property(step_i&&!ccw_i|=>count_o==$past(count_o)+1)else $error("u");
AST_DN: assert property(step_i&&ccw_i|=>count_o==$past(count_o)-1)else $error("d");
AST_HOLD: assert property(!step_i|=>$stable(count_o))else $error("h");
AST_PULSE: assert property(s|->##2 cmd_o)else $error("p");
AST_END: assert property(s##1!step_i|->##2!cmd_o)else $error("e");
AST_DIR: assert property(s|->##2 dir_o==$past(ccw_i,2))else $error("r");
AST_TWO: assert property(step_i&&fmt_i==4|->##2
cmd_o^dir_o&&dir_o==$past(ccw_i,2))else $error("t");
AST_QUAD: assert property(step_i&&fmt_i>5|->##2
$changed(cmd_o)^$changed(dir_o))else $error("q");
cover property(s&&ccw_i);
cover property(step_i&&fmt_i==4);
cover property(step_i&&fmt_i>5);
endmodule
bind motion_pulse_output_former mpa_asserts i_mpa_asserts(.*);

// >>> sim/drive_model.sv
// Purpose: driver input model
// Assumes: one line moves per quad step
// Notes: pos_o sums decoded steps
`timescale 1ns/100ps
module drive_model import pulse_former_pkg::*; (
input logic clk_i,rst_n_i,cmd_i,dir_i,
input fmt_t fmt_i,
output logic signed [31:0] pos_o);
logic pc,pd;
wire a=cmd_i^pc;
wire signed [31:0] d=fmt_i<4?(cmd_i^fmt_i[0]&&!(pc^fmt_i[0])?(dir_i^fmt_i[1]?-1:1):0)
:fmt_i==4?(cmd_i&&!pc?1:dir_i&&!pd?-1:0)
:fmt_i>5&&a|dir_i^pd?(!(a^cmd_i^dir_i)^fmt_i[0]?1:-1):0;
always_ff @(posedge clk_i or negedge rst_n_i)
if(!rst_n_i) {pos_o,pc,pd}<='0;
else {pos_o,pc,pd}<={pos_o+d,cmd_i,dir_i};
endmodule

// >>> sim/motion_pulse_output_former_tb.sv
// Purpose: bench
// Assumes: 40 MHz clock
// Notes: steps keep an idle cycle
`timescale 1ns/100ps
module motion_pulse_output_former_tb;
import pulse_former_pkg::*;
logic clk_i=0,rst_n_i=0,step_i=0,ccw_i=0,cmd_o,dir_o;
fmt_t fmt_i=0;
count_t count_o,e=0,pos,p;
int failures=0,comparisons=0;
motion_pulse_output_former i_motion_pulse_output_former(.*);
drive_model i_drive_model(.cmd_i(cmd_o),.dir_i(dir_o),.pos_o(pos),.*);
initial forever #12.5 clk_i=~clk_i;
task chk(string n,count_t x,s);comparisons++;
if(x!==s)begin failures++;$display("MISMATCH %s %h %h",n,x,s);end endtask
task final_report;if(failures==0&&comparisons>0)$display("== PASSED ==");
else $display("== FAILED ==");$finish;endtask
task run(fmt_t f,bit c,int n);@(posedge clk_i);fmt_i<=f;repeat(5)@(posedge clk_i);p=pos;
repeat(n)begin step_i<=1;ccw_i<=c;@(posedge clk_i);step_i<=0;@(posedge clk_i);end
repeat(3)@(posedge clk_i);#1 e=c?e-n:e+n;
chk("count",e,count_o);chk("travel",c?-n:n,pos-p);endtask
task t_pd;for(int f=0;f<4;f++)begin run(f,1,2);run(f,0,3);chk("idle",f[0],cmd_o);end endtask
task t_two;run(4,0,2);run(4,1,3);endtask
task t_quad;run(6,0,4);run(6,1,3);run(7,0,4);run(7,1,3);endtask
initial begin repeat(5)@(posedge clk_i);rst_n_i<=1;t_pd;t_two;t_quad;final_report;end
endmodule
